// [rtl/csfo_map.svh]
// Constants for the store, shift and flag execution slice.
// Assumes an 8-bit data path and a 16-bit data address space.
`ifndef CSFO_MAP_SVH
`define CSFO_MAP_SVH

// Flag positions inside the flags register
`define CSFO_FLAG_C 3'h0
`define CSFO_FLAG_Z 3'h1
`define CSFO_FLAG_N 3'h2
`define CSFO_FLAG_V 3'h3
`define CSFO_FLAG_S 3'h4
`define CSFO_FLAG_H 3'h5
`define CSFO_FLAG_T 3'h6
`define CSFO_FLAG_I 3'h7

// Reset values
`define CSFO_FLAGS_RST 8'h00
`define CSFO_SP_RST 16'h0000

// Execution lengths in core clocks
`define CSFO_CYC_MEM 2
`define CSFO_CYC_ALU 1

`endif

// [rtl/csfo_pkg.sv]
// Types shared by the store, shift and flag execution slice.
// Assumes the decoder ahead of it has already picked out the operands.
package csfo_pkg;

   // Operation selected by the decoder
   typedef enum logic [4:0] {
      CSFO_WR_PLAIN,   // indirect_write, pointer untouched
      CSFO_WR_POSTINC, // indirect_write, then pointer + 1
      CSFO_WR_PREDEC,  // pointer - 1, then indirect_write
      CSFO_WR_DISP,    // displaced_write
      CSFO_WR_DIRECT,  // direct_write
      CSFO_PUSH,       // source onto stack
      CSFO_POP,        // destination from stack
      CSFO_IO_SET,     // io_bit_set
      CSFO_IO_CLR,     // io_bit_clear
      CSFO_SHL,        // shift_left_logical
      CSFO_SHR,        // shift_right_logical
      CSFO_ROL,        // rotate_left_carry
      CSFO_ROR,        // rotate_right_carry
      CSFO_ASR,        // arith_right_shift
      CSFO_SWAP,       // nibble exchange
      CSFO_CAPT,       // flag_capture_bit
      CSFO_DEPO,       // flag_deposit_bit
      CSFO_FSET,       // flag_force_one
      CSFO_FCLR        // flag_force_zero
   } csfo_op_t;

   // One decoded instruction with its operands
   typedef struct packed {
      csfo_op_t op;      // Operation
      logic [7:0] src;   // Source or destination register value
      logic [15:0] ptr;  // Pointer pair value
      logic [5:0] disp;  // Displacement
      logic [15:0] addr; // Direct data address
      logic [4:0] io;    // I/O register address
      logic [2:0] bsel;  // Bit or flag index
   } csfo_cmd_t;

endpackage

// [rtl/csfo_core.sv]
// Execution slice: data stores, stack, I/O bit ops, shifts and flag ops.
// Assumes memory and I/O read data stands while the read strobe is up and
// is taken at the edge that ends it. Register file writeback is done by the caller.
//
// Notes on behaviour
// RL1: post-increment write stores, then pointer plus one
// RL2: pre-decrement write decrements pointer, then stores
// RL3: displaced write uses pointer plus displacement
// RL4: direct write uses address from instruction
// RL5: push stores source on stack, two cycles
// RL6: pop loads destination from stack, two cycles
// RL7: I/O bit set forces chosen bit high
// RL8: I/O bit clear forces chosen bit low
// RL9: left shift fills zero, sets Z C N V
// RL10: right shift fills zero, sets Z C N V
// RL11: rotate left through carry, sets Z C N V
// RL12: rotate right through carry, sets Z C N V
// RL13: arithmetic right shift keeps bit seven
// RL14: nibble swap, one cycle, flags untouched
// RL15: capture register bit into transfer flag
// RL16: deposit transfer flag into register bit
// RL17: flag set forces only that flag high
// RL18: flag clear forces only that flag low
// RL19: pointer arithmetic is full sixteen bit, wrapping
`timescale 1ns/100ps
`include "csfo_map.svh"

module csfo_core
   import csfo_pkg::*;
#(
   parameter logic [15:0] SP_INIT = `CSFO_SP_RST // Stack pointer after reset
) (
   input wire logic clk,               // 25 MHz core clock
   input wire logic resetn,            // Asynchronous reset, active low
   input wire logic cmd_valid,         // Decoded instruction present
   input wire csfo_cmd_t cmd,          // Decoded instruction
   input wire logic [7:0] mem_rdata,   // Data memory read data
   input wire logic [7:0] io_rdata,    // I/O register read data
   output logic cmd_ready,             // Slice can take an instruction
   output logic done,                  // Instruction finished, pulse
   output logic mem_we,                // Data memory write strobe
   output logic mem_re,                // Data memory read strobe
   output logic [15:0] mem_addr,       // Data memory address
   output logic [7:0] mem_wdata,       // Data memory write data
   output logic io_we,                 // I/O write strobe
   output logic io_re,                 // I/O read strobe
   output logic [4:0] io_addr,         // I/O register address
   output logic [7:0] io_wdata,        // I/O write data
   output logic rd_we,                 // Register writeback strobe
   output logic [7:0] rd_wdata,        // Register writeback value
   output logic ptr_we,                // Pointer pair writeback strobe
   output logic [15:0] ptr_wdata,      // Pointer pair writeback value
   output logic [15:0] sp,             // Stack pointer
   output logic [7:0] flags_register   // Status flags
);

   typedef enum logic {CSFO_IDLE, CSFO_MEM} csfo_state_t;

   csfo_state_t state_r, state_nxt;     // Sequencer state
   csfo_cmd_t cmd_r;                    // Held two-cycle instruction
   logic [7:0] flags_r, flags_nxt;      // Status flags
   logic [15:0] sp_r, sp_nxt;           // Stack pointer
   logic ready_r, done_r;               // Handshake outputs
   logic mem_we_r, mem_re_r, io_we_r, io_re_r, rd_we_r, ptr_we_r;
   logic [15:0] mem_addr_r, ptr_wdata_r;
   logic [7:0] mem_wdata_r, io_wdata_r, rd_wdata_r;
   logic [4:0] io_addr_r;

   // Decode of the incoming instruction
   wire accept = (state_r == CSFO_IDLE) && cmd_valid;
   wire is_wr = (cmd.op == CSFO_WR_PLAIN) || (cmd.op == CSFO_WR_POSTINC) ||
                (cmd.op == CSFO_WR_PREDEC) || (cmd.op == CSFO_WR_DISP) ||
                (cmd.op == CSFO_WR_DIRECT) || (cmd.op == CSFO_PUSH);
   wire is_io = (cmd.op == CSFO_IO_SET) || (cmd.op == CSFO_IO_CLR);
   wire is_pop = cmd.op == CSFO_POP;
   wire two_cyc = is_wr || is_io || is_pop;
   wire is_shift = (cmd.op == CSFO_SHL) || (cmd.op == CSFO_SHR) ||
                   (cmd.op == CSFO_ROL) || (cmd.op == CSFO_ROR) ||
                   (cmd.op == CSFO_ASR);
   wire [7:0] bmask = 8'h01 << cmd.bsel;
   wire [7:0] hmask = 8'h01 << cmd_r.bsel;

   // Pointer arithmetic on the whole pair; natural 16-bit wrap
   wire [15:0] ptr_inc = cmd.ptr + 16'h0001; // RL19
   wire [15:0] ptr_dec = cmd.ptr - 16'h0001; // RL19
   wire [15:0] ptr_dsp = cmd.ptr + {10'h000, cmd.disp};
   wire [15:0] sp_inc = sp_r + 16'h0001;
   wire [15:0] sp_dec = sp_r - 16'h0001;

   // Store address for each write flavour
   wire [15:0] wr_addr =
      (cmd.op == CSFO_WR_PREDEC) ? ptr_dec : // RL2
      (cmd.op == CSFO_WR_DISP)   ? ptr_dsp : // RL3
      (cmd.op == CSFO_WR_DIRECT) ? cmd.addr : // RL4
      (cmd.op == CSFO_PUSH)      ? sp_r :    // RL5
      cmd.ptr;                               // RL1

   // Pointer writeback value; only the two stepping writes update it
   wire [15:0] ptr_new = (cmd_r.op == CSFO_WR_PREDEC) ? cmd_r.ptr - 16'h0001 :
                         cmd_r.ptr + 16'h0001;
   wire ptr_step = (cmd_r.op == CSFO_WR_POSTINC) || (cmd_r.op == CSFO_WR_PREDEC);

   // Shift and rotate results with the carry they produce
   wire cin = flags_r[`CSFO_FLAG_C];
   wire [7:0] s = cmd.src;
   wire [7:0] sh_res =
      (cmd.op == CSFO_SHL) ? {s[6:0], 1'b0} : // RL9
      (cmd.op == CSFO_SHR) ? {1'b0, s[7:1]} : // RL10
      (cmd.op == CSFO_ROL) ? {s[6:0], cin} :  // RL11
      (cmd.op == CSFO_ROR) ? {cin, s[7:1]} :  // RL12
      {s[7], s[7:1]};                         // RL13
   wire sh_c = ((cmd.op == CSFO_SHL) || (cmd.op == CSFO_ROL)) ? s[7] : s[0];
   wire sh_n = sh_res[7];
   wire sh_z = sh_res == 8'h00;

   // Register writeback value for one-cycle operations
   wire [7:0] alu_res =
      is_shift ? sh_res :
      (cmd.op == CSFO_SWAP) ? {s[3:0], s[7:4]} : // RL14
      flags_r[`CSFO_FLAG_T] ? (s | bmask) : (s & ~bmask); // RL16
   wire alu_we = is_shift || (cmd.op == CSFO_SWAP) || (cmd.op == CSFO_DEPO);

   // Read-modify-write value for the I/O bit operations
   wire [7:0] io_mod = (cmd_r.op == CSFO_IO_SET) ? (io_rdata | hmask) : // RL7
                       (io_rdata & ~hmask);                              // RL8

   // Flag update; memory and I/O operations leave the flags alone
   always_comb begin
      flags_nxt = flags_r;
      if (accept && is_shift) begin
         flags_nxt[`CSFO_FLAG_C] = sh_c;        // RL9
         flags_nxt[`CSFO_FLAG_Z] = sh_z;        // RL10
         flags_nxt[`CSFO_FLAG_N] = sh_n;        // RL11
         flags_nxt[`CSFO_FLAG_V] = sh_n ^ sh_c; // RL12
      end else if (accept && cmd.op == CSFO_CAPT) begin
         flags_nxt[`CSFO_FLAG_T] = s[cmd.bsel]; // RL15
      end else if (accept && cmd.op == CSFO_FSET) begin
         flags_nxt[cmd.bsel] = 1'b1;            // RL17
      end else if (accept && cmd.op == CSFO_FCLR) begin
         flags_nxt[cmd.bsel] = 1'b0;            // RL18
      end
   end

   // Stack pointer: push post-decrements, pop pre-increments
   assign sp_nxt = !accept ? sp_r :
                   (cmd.op == CSFO_PUSH) ? sp_dec :
                   is_pop ? sp_inc : sp_r;

   // Two-cycle operations park in the memory state for one clock
   assign state_nxt = (accept && two_cyc) ? CSFO_MEM : CSFO_IDLE;

   // Sequencer, flags and stack pointer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= CSFO_IDLE;
         flags_r <= `CSFO_FLAGS_RST;
         sp_r <= SP_INIT;
         ready_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         flags_r <= flags_nxt;
         sp_r <= sp_nxt;
         ready_r <= state_nxt == CSFO_IDLE;
         // One-cycle ops finish at once, the rest one clock later
         done_r <= (accept && !two_cyc) || (state_r == CSFO_MEM);
      end
   end

   // Hold the instruction for its second clock
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmd_r <= '0;
      end else if (accept) begin
         cmd_r <= cmd;
      end
   end

   // First clock: drive the memory or I/O access
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mem_we_r <= 1'b0;
         mem_re_r <= 1'b0;
         io_re_r <= 1'b0;
         mem_addr_r <= 16'h0000;
         mem_wdata_r <= 8'h00;
      end else begin
         mem_we_r <= accept && is_wr; // RL4
         mem_re_r <= accept && is_pop; // RL6
         io_re_r <= accept && is_io;
         if (accept && (is_wr || is_pop)) begin
            mem_addr_r <= is_pop ? sp_inc : wr_addr;
            mem_wdata_r <= cmd.src; // RL5
         end
      end
   end

   // Second clock for I/O: write back the modified byte
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_we_r <= 1'b0;
         io_addr_r <= 5'h00;
         io_wdata_r <= 8'h00;
      end else begin
         io_we_r <= (state_r == CSFO_MEM) && (cmd_r.op inside {CSFO_IO_SET, CSFO_IO_CLR});
         if (accept && is_io) begin
            io_addr_r <= cmd.io;
         end
         if (state_r == CSFO_MEM) begin
            io_wdata_r <= io_mod;
         end
      end
   end

   // Register and pointer writeback
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_we_r <= 1'b0;
         rd_wdata_r <= 8'h00;
         ptr_we_r <= 1'b0;
         ptr_wdata_r <= 16'h0000;
      end else begin
         rd_we_r <= (accept && alu_we) || ((state_r == CSFO_MEM) && cmd_r.op == CSFO_POP);
         if (state_r == CSFO_MEM) begin
            rd_wdata_r <= mem_rdata; // RL6
         end else if (accept) begin
            rd_wdata_r <= alu_res;
         end
         // Pointer steps only for the post-increment and pre-decrement forms
         ptr_we_r <= (state_r == CSFO_MEM) && ptr_step; // RL1
         if (state_r == CSFO_MEM) begin
            ptr_wdata_r <= ptr_new; // RL19
         end
      end
   end

   // Outputs straight from flip-flops
   assign cmd_ready = ready_r;
   assign done = done_r;
   assign mem_we = mem_we_r;
   assign mem_re = mem_re_r;
   assign mem_addr = mem_addr_r;
   assign mem_wdata = mem_wdata_r;
   assign io_we = io_we_r;
   assign io_re = io_re_r;
   assign io_addr = io_addr_r;
   assign io_wdata = io_wdata_r;
   assign rd_we = rd_we_r;
   assign rd_wdata = rd_wdata_r;
   assign ptr_we = ptr_we_r;
   assign ptr_wdata = ptr_wdata_r;
   assign sp = sp_r;
   assign flags_register = flags_r;

   // Checks
   sequence s_take(csfo_op_t o);
      accept && cmd.op == o;
   endsequence

   sequence s_finish;
      ##1 !done_r ##1 done_r;
   endsequence

   property p_postinc;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_WR_POSTINC) |=> mem_we_r && mem_addr_r == $past(cmd.ptr)
         ##1 ptr_we_r && ptr_wdata_r == $past(cmd.ptr, 2) + 16'h0001 && done_r;
   endproperty
   a_postinc: assert property (p_postinc) else $error("post-increment write wrong"); // RL1

   property p_predec;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_WR_PREDEC) |=> mem_addr_r == $past(cmd.ptr) - 16'h0001
         ##1 ptr_we_r && ptr_wdata_r == mem_addr_r;
   endproperty
   a_predec: assert property (p_predec) else $error("pre-decrement write wrong"); // RL2

   property p_disp;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_WR_DISP) |=> mem_we_r &&
         mem_addr_r == $past(cmd.ptr) + {10'h000, $past(cmd.disp)} ##1 !ptr_we_r;
   endproperty
   a_disp: assert property (p_disp) else $error("displaced write wrong"); // RL3

   property p_push;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_PUSH) |-> (s_finish and
         (##1 mem_we_r && mem_wdata_r == $past(cmd.src) && $stable(flags_r)));
   endproperty
   a_push: assert property (p_push) else $error("push wrong"); // RL5

   property p_pop;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_POP) |=> mem_re_r ##1 rd_we_r && done_r && rd_wdata_r == $past(mem_rdata);
   endproperty
   a_pop: assert property (p_pop) else $error("pop wrong"); // RL6

   property p_ioset;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_IO_SET) ##1 1'b1 |=> io_we_r && io_wdata_r[cmd_r.bsel] == 1'b1;
   endproperty
   a_ioset: assert property (p_ioset) else $error("I/O bit set wrong"); // RL7

   property p_shl;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_SHL) |=> done_r && rd_wdata_r == {$past(cmd.src[6:0]), 1'b0} &&
         flags_r[`CSFO_FLAG_C] == $past(cmd.src[7]);
   endproperty
   a_shl: assert property (p_shl) else $error("left shift wrong"); // RL9

   property p_ror;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_ROR) |=> rd_wdata_r[7] == $past(flags_r[`CSFO_FLAG_C]) &&
         flags_r[`CSFO_FLAG_C] == $past(cmd.src[0]);
   endproperty
   a_ror: assert property (p_ror) else $error("rotate right wrong"); // RL12

   property p_swap;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_SWAP) |=> $stable(flags_r) && rd_wdata_r == {$past(cmd.src[3:0]),
         $past(cmd.src[7:4])};
   endproperty
   a_swap: assert property (p_swap) else $error("nibble swap wrong"); // RL14

   property p_capt;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_CAPT) |=> flags_r[`CSFO_FLAG_T] == $past(cmd.src[cmd.bsel]) && !rd_we_r;
   endproperty
   a_capt: assert property (p_capt) else $error("bit capture wrong"); // RL15

   property p_fclr;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_FCLR) |=> flags_r == ($past(flags_r) & ~(8'h01 << $past(cmd.bsel)));
   endproperty
   a_fclr: assert property (p_fclr) else $error("flag clear wrong"); // RL18

   // Direct write: address from the instruction, pointer left alone
   property p_direct;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_WR_DIRECT) |=> mem_we_r && mem_addr_r == $past(cmd.addr) &&
         mem_wdata_r == $past(cmd.src) ##1 done_r && !ptr_we_r;
   endproperty
   a_direct: assert property (p_direct) else $error("direct write wrong"); // RL4

   // Bit clear must keep every other bit of the byte read back
   property p_ioclr;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_IO_CLR) ##1 1'b1 |=> io_we_r && io_wdata_r == ($past(io_rdata) & ~hmask);
   endproperty
   a_ioclr: assert property (p_ioclr) else $error("I/O bit clear wrong"); // RL8

   // Flag set touches only the indexed bit
   property p_fset;
      @(posedge clk) disable iff (!resetn)
      s_take(CSFO_FSET) |=> done_r && flags_r == ($past(flags_r) | (8'h01 << $past(cmd.bsel)));
   endproperty
   a_fset: assert property (p_fset) else $error("flag set wrong"); // RL17

endmodule

// [sim/csfo_mem_model.sv]
// Behavioural data memory and I/O space beside the execution slice.
// Assumes one-cycle strobes with address and data held alongside.
`timescale 1ns/100ps
module csfo_mem_model (
   input wire logic clk, // Core clock
   input wire logic mem_we, // Memory write strobe
   input wire logic mem_re, // Memory read strobe
   input wire logic [15:0] mem_addr, // Memory address
   input wire logic [7:0] mem_wdata, // Memory write data
   output logic [7:0] mem_rdata, // Memory read data
   input wire logic io_we, // I/O write strobe
   input wire logic io_re, // I/O read strobe
   input wire logic [4:0] io_addr, // I/O address
   input wire logic [7:0] io_wdata, // I/O write data
   output logic [7:0] io_rdata // I/O read data
);
   logic [7:0] mem [0:255]; // Low address byte only, so wrap tests alias
   logic [7:0] io [0:31]; // I/O registers
   logic [7:0] m_hold, i_hold; // Data seen while a strobe was up
   logic m_last, i_last; // Read strobe one clock ago
   // Every I/O register starts at 55
   initial begin
      for (int i = 0; i < 32; i++) io[i] = 8'h55;
   end
   // Writes land on the edge; read data is kept one clock past the strobe
   always @(posedge clk) begin
      if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
      if (io_we) io[io_addr] <= io_wdata;
      if (mem_re) m_hold <= mem[mem_addr[7:0]];
      if (io_re) i_hold <= io[io_addr];
      m_last <= mem_re;
      i_last <= io_re;
   end
   // Outside the valid time the lines show the inverse, never stale data
   assign mem_rdata = mem_re ? mem[mem_addr[7:0]] : (m_last ? m_hold : ~m_hold);
   assign io_rdata = io_re ? io[io_addr] : (i_last ? i_hold : ~i_hold);
endmodule

// [sim/test_cpu_store_shift_flag_ops.sv]
// Self-checking bench for the store, shift and flag execution slice.
// Assumes the memory model answers reads and keeps the I/O space.
`timescale 1ns/100ps
module test_cpu_store_shift_flag_ops;
   import csfo_pkg::*;
   logic clk, resetn, cmd_valid, cmd_ready, done, mem_we, mem_re, io_we, io_re;
   logic rd_we, ptr_we;
   csfo_cmd_t cmd; // Instruction driven to the slice
   logic [7:0] mem_rdata, mem_wdata, io_rdata, io_wdata, rd_wdata, flags_register;
   logic [15:0] mem_addr, ptr_wdata, sp;
   logic [4:0] io_addr;
   logic [15:0] w_a, p_d; // Last memory write address, last pointer
   logic [7:0] w_d, r_d, io_d; // Last memory, register and I/O data
   logic [4:0] io_a; // Last I/O write address
   int n_fail = 0, check_count = 0, cycles = 0, lat;
   csfo_cmd_t c;
   logic [7:0] f0;
   csfo_core uut (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
      .mem_rdata(mem_rdata), .io_rdata(io_rdata), .cmd_ready(cmd_ready), .done(done),
      .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .io_we(io_we), .io_re(io_re), .io_addr(io_addr), .io_wdata(io_wdata),
      .rd_we(rd_we), .rd_wdata(rd_wdata), .ptr_we(ptr_we), .ptr_wdata(ptr_wdata),
      .sp(sp), .flags_register(flags_register));
   csfo_mem_model mdl (.clk(clk), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .io_we(io_we), .io_re(io_re),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Strobes are single cycles, so latch what each one carried
   always @(posedge clk) begin
      if (mem_we) begin
         w_a <= mem_addr;
         w_d <= mem_wdata;
      end
      if (rd_we) r_d <= rd_wdata;
      if (ptr_we) p_d <= ptr_wdata;
      if (io_we) begin
         io_a <= io_addr;
         io_d <= io_wdata;
      end
   end
   // Whole run needs a few hundred clocks; a hang is cut short here
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_fail++;
         results();
      end
   end
   task results;
      if (n_fail == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic csfo_cmd_t mk(csfo_op_t op, logic [7:0] s, logic [15:0] p);
      mk = '0;
      mk.op = op;
      mk.src = s;
      mk.ptr = p;
   endfunction
   // Issue one instruction and return clocks from take to done
   task automatic exec(input csfo_cmd_t ci);
      @(negedge clk);
      while (cmd_ready !== 1'b1) @(negedge clk);
      f0 = flags_register;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= ci;
      @(posedge clk);
      cmd_valid <= 1'b0;
      lat = 0;
      do begin
         @(negedge clk);
         lat++;
      end while (done !== 1'b1 && lat < 8);
      // A missing done is a fault even where the caller skips the count
      if (done !== 1'b1) begin
         n_fail++;
         $display("MISMATCH %0t no done after instruction", $time);
      end
      // I/O write strobe comes with done; its data is latched on the following edge
      repeat (2) @(negedge clk);
   endtask
   // Post-increment at the top of memory wraps the pointer
   task t_postinc;
      exec(mk(CSFO_WR_POSTINC, 8'h3c, 16'hffff));
      chk(16'(lat), 16'h2);
      chk(w_a, 16'hffff);
      chk(16'(w_d), 16'h3c);
      chk(p_d, 16'h0000);
      chk(16'(flags_register), 16'(f0));
   endtask
   // Pre-decrement from zero wraps, store goes to the new address
   task t_predec;
      exec(mk(CSFO_WR_PREDEC, 8'hc3, 16'h0000));
      chk(16'(lat), 16'h2);
      chk(w_a, 16'hffff);
      chk(16'(w_d), 16'hc3);
      chk(p_d, 16'hffff);
      chk(16'(flags_register), 16'(f0));
   endtask
   // Displacement carries into the high byte; direct uses its own address
   task t_offsets;
      c = mk(CSFO_WR_DISP, 8'h96, 16'h10c1);
      c.disp = 6'h3f;
      exec(c);
      chk(16'(lat), 16'h2);
      chk(w_a, 16'h1100);
      chk(16'(w_d), 16'h96);
      c = mk(CSFO_WR_DIRECT, 8'h69, 16'h0000);
      c.addr = 16'h1234;
      exec(c);
      chk(16'(lat), 16'h2);
      chk(w_a, 16'h1234);
      chk(16'(w_d), 16'h69);
      chk(16'(flags_register), 16'(f0));
   endtask
   // Push then pop must give back the same byte and the same stack pointer
   task t_stack;
      logic [15:0] s0;
      s0 = sp;
      exec(mk(CSFO_PUSH, 8'ha7, 16'h0000));
      chk(16'(lat), 16'h2);
      chk(w_a, s0);
      chk(sp, s0 - 16'h1);
      exec(mk(CSFO_POP, 8'h00, 16'h0000));
      chk(16'(lat), 16'h2);
      chk(16'(r_d), 16'ha7);
      chk(sp, s0);
      chk(16'(flags_register), 16'(f0));
   endtask
   // Bit set and clear touch one bit of a 55 register
   task t_io;
      c = mk(CSFO_IO_SET, 8'h00, 16'h0000);
      c.io = 5'h1f;
      c.bsel = 3'h1;
      exec(c);
      chk(16'(lat), 16'h2);
      chk({11'h0, io_a}, 16'h1f);
      chk(16'(io_d), 16'h57);
      c.op = CSFO_IO_CLR;
      c.io = 5'h02;
      c.bsel = 3'h6;
      exec(c);
      chk(16'(lat), 16'h2);
      chk(16'(io_d), 16'h15);
      chk(16'(flags_register), 16'(f0));
   endtask
   // Every shift with both carry values and a zero result
   task t_shift;
      csfo_op_t ops [5] = '{CSFO_SHL, CSFO_SHR, CSFO_ROL, CSFO_ROR, CSFO_ASR};
      logic [7:0] s, r, ef;
      logic co, ci;
      for (int k = 0; k < 20; k++) begin
         ci = k[0];
         s = k[1] ? 8'h81 : 8'h00;
         c = mk(ci ? CSFO_FSET : CSFO_FCLR, 8'h00, 16'h0000);
         exec(c);
         exec(mk(ops[k / 4], s, 16'h0000));
         case (ops[k / 4])
            CSFO_SHL: {co, r} = {s, 1'b0};
            CSFO_SHR: {r, co} = {1'b0, s};
            CSFO_ROL: {co, r} = {s, ci};
            CSFO_ROR: {r, co} = {ci, s};
            default: {r, co} = {s[7], s};
         endcase
         ef = {f0[7:4], r[7] ^ co, r[7], r == 8'h00, co};
         chk(16'(lat), 16'h1);
         chk(16'(r_d), 16'(r));
         chk(16'(flags_register), 16'(ef));
      end
   endtask
   // Nibble swap, then capture and deposit of the transfer flag
   task t_bits;
      exec(mk(CSFO_SWAP, 8'h3c, 16'h0000));
      chk(16'(lat), 16'h1);
      chk(16'(r_d), 16'hc3);
      chk(16'(flags_register), 16'(f0));
      for (int k = 0; k < 2; k++) begin
         c = mk(CSFO_CAPT, k ? 8'hdf : 8'h20, 16'h0000);
         c.bsel = 3'h5;
         exec(c);
         chk(16'(lat), 16'h1);
         chk(16'(flags_register), 16'({f0[7], ~k[0], f0[5:0]}));
         c = mk(CSFO_DEPO, k ? 8'hff : 8'h00, 16'h0000);
         c.bsel = k ? 3'h0 : 3'h3;
         exec(c);
         chk(16'(r_d), k ? 16'hfe : 16'h08);
         chk(16'(flags_register), 16'(f0));
      end
   endtask
   // Each flag index forced high, then low, one at a time
   task t_flags;
      for (int k = 0; k < 16; k++) begin
         c = mk(k < 8 ? CSFO_FSET : CSFO_FCLR, 8'h00, 16'h0000);
         c.bsel = 3'(k);
         exec(c);
         chk(16'(lat), 16'h1);
         chk(16'(flags_register),
            16'(k < 8 ? f0 | (8'h1 << k[2:0]) : f0 & ~(8'h1 << k[2:0])));
      end
   endtask
   // Reset for 12 clocks, then the scenarios in turn
   initial begin
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_postinc();
      t_predec();
      t_offsets();
      t_stack();
      t_io();
      t_shift();
      t_bits();
      t_flags();
      results();
   end
endmodule
